/* src/iem_regs.svh */
// register offsets, field positions and reset values of the enable bits
`ifndef IEM_REGS_SVH
`define IEM_REGS_SVH
`define IEM_OFF_FIRST     12'h000
`define IEM_OFF_SECOND    12'h004
`define IEM_OFF_SOURCES   12'h008
`define IEM_OFF_GATED     12'h00C
`define IEM_OFF_PENDING   12'h010
`define IEM_RST_FIRST     16'h0000
`define IEM_RST_SECOND    16'h0000
`define IEM_MASK_FIRST    16'hFFFF
`define IEM_MASK_SECOND   16'hFFFB
`define IEM_BIT_EXT0      0
`define IEM_BIT_CAP1      1
`define IEM_BIT_CMP1      2
`define IEM_BIT_I2C_SLV   0
`define IEM_BIT_I2C_MST   1
`define IEM_BIT_UNIMPL    2
`define IEM_BIT_CHG       3
`define IEM_BIT_CMP4      10
`define IEM_BIT_TMR5      12
`define IEM_NSRC          32
`define IEM_RESP_OKAY     2'h0
`define IEM_RESP_SLVERR   2'h2
`endif

/* src/iem_pkg.sv */
// types shared by the enable-bit block
package iem_pkg;
    typedef struct packed {
        logic [11:0] addr;   // byte address
        logic [31:0] data;   // write data
        logic [3:0]  strb;   // byte lanes
    } iem_wr_t;
    typedef enum logic [2:0] {
        IEM_W_IDLE = 3'b001,
        IEM_W_RESP = 3'b010,
        IEM_W_SPARE = 3'b100
    } iem_wst_t;
endpackage : iem_pkg

/* src/iem_gate.sv */
// per-source gating of requests by enable bits
`timescale 1ns/1ps
`include "iem_regs.svh"
module iem_gate (
    input  wire logic                 aclk,     // system clock
    input  wire logic                 aresetn,  // sync reset, low active
    input  wire logic [`IEM_NSRC-1:0] req,      // synchronised source flags
    input  wire logic [`IEM_NSRC-1:0] en,       // enable bits
    output logic      [`IEM_NSRC-1:0] gated_q   // registered gated requests
);
    logic [`IEM_NSRC-1:0] gated_d; // next gated value
    ////////////////////////////////////////////////////////////////////////
    // one gate per source
    genvar g;
    generate
        for (g = 0; g < `IEM_NSRC; g++) begin : g_src
            always_comb begin
                gated_d[g] = req[g] & en[g];
            end
        end
    endgenerate
    // register the gated vector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gated_q <= '0;
        end else begin
            gated_q <= gated_d;
        end
    end
endmodule : iem_gate

/* src/iem_top.sv */
// interrupt enable registers with axi4-lite slave and request gating
// Operation
// - first register bit 2 gates compare one
// - first register bit 1 gates capture one
// - first register bit 0 gates external pin zero
// - one passes request, zero blocks it
// - second register bit 12 gates timer five
// - second register bit 10 gates compare four
// - second register bit 2 reads zero always
// - second register bit 3 gates change notify
// - bits 1/0 gate i2c master/slave events
`timescale 1ns/1ps
`include "iem_regs.svh"
module iem_top (
    input  wire logic        aclk,           // 50 mhz system clock
    input  wire logic        aresetn,        // sync reset, low active
    input  wire logic [11:0] s_axi_awaddr,   // write address
    input  wire logic        s_axi_awvalid,  // write address valid
    output logic             s_axi_awready,  // write address ready
    input  wire logic [31:0] s_axi_wdata,    // write data
    input  wire logic [3:0]  s_axi_wstrb,    // write strobes
    input  wire logic        s_axi_wvalid,   // write data valid
    output logic             s_axi_wready,   // write data ready
    output logic [1:0]       s_axi_bresp,    // write response
    output logic             s_axi_bvalid,   // write response valid
    input  wire logic        s_axi_bready,   // write response ready
    input  wire logic [11:0] s_axi_araddr,   // read address
    input  wire logic        s_axi_arvalid,  // read address valid
    output logic             s_axi_arready,  // read address ready
    output logic [31:0]      s_axi_rdata,    // read data
    output logic [1:0]       s_axi_rresp,    // read response
    output logic             s_axi_rvalid,   // read data valid
    input  wire logic        s_axi_rready,   // read data ready
    input  wire logic [31:0] src_req,        // raw peripheral flags
    output logic      [31:0] irq_gated_q     // gated requests to priority logic
);
    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [15:0] ena_first_q, ena_first_d;    // first enable register
    logic [15:0] ena_second_q, ena_second_d;  // second enable register
    logic        aw_held_q, aw_held_d;        // address captured
    logic        w_held_q, w_held_d;          // data captured
    logic [11:0] awaddr_q, awaddr_d;          // captured write address
    logic [31:0] wdata_q, wdata_d;            // captured write data
    logic [3:0]  wstrb_q, wstrb_d;            // captured strobes
    logic        bvalid_q, bvalid_d;          // response pending
    logic [1:0]  bresp_q, bresp_d;            // response code
    logic        rvalid_q, rvalid_d;          // read pending
    logic [31:0] rdata_q, rdata_d;            // read data
    logic [1:0]  rresp_q, rresp_d;            // read response code
    logic        awready_q, awready_d;        // write address ready
    logic        wready_q, wready_d;          // write data ready
    logic        arready_q, arready_d;        // read address ready
    logic [31:0] req_s1_q, req_s2_q;          // source synchroniser
    logic [31:0] en_vec;                      // enables per source
    logic [31:0] gated;                       // from gate module
    logic        do_write;                    // both halves present
    iem_pkg::iem_wr_t wr;                     // assembled write
    logic [31:0] wmask;                       // strobe expansion

    ////////////////////////////////////////////////////////////////////////
    // synchronise peripheral flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_s1_q <= '0;
            req_s2_q <= '0;
        end else begin
            req_s1_q <= src_req;
            req_s2_q <= req_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write channel next-state and register writes
    always_comb begin
        aw_held_d    = aw_held_q;
        w_held_d     = w_held_q;
        awaddr_d     = awaddr_q;
        wdata_d      = wdata_q;
        wstrb_d      = wstrb_q;
        bvalid_d     = bvalid_q;
        bresp_d      = bresp_q;
        ena_first_d  = ena_first_q;
        ena_second_d = ena_second_q;
        // capture address
        if (s_axi_awvalid && awready_q) begin
            aw_held_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        // capture data
        if (s_axi_wvalid && wready_q) begin
            w_held_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        wr.addr  = awaddr_q;
        wr.data  = wdata_q;
        wr.strb  = wstrb_q;
        do_write = aw_held_q && w_held_q && !bvalid_q;
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{wr.strb[i]}};
        end
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = `IEM_RESP_OKAY;
            if (wr.addr == `IEM_OFF_FIRST) begin
                // bits 2..0 feed compare one, capture one, pin zero
                ena_first_d = ((ena_first_q & ~wmask[15:0])
                    | (wr.data[15:0] & wmask[15:0])) & `IEM_MASK_FIRST;
            end else if (wr.addr == `IEM_OFF_SECOND) begin
                // bit 2 masked off so it never stores
                ena_second_d = ((ena_second_q & ~wmask[15:0])
                    | (wr.data[15:0] & wmask[15:0])) & `IEM_MASK_SECOND;
            end else if (wr.addr == `IEM_OFF_SOURCES || wr.addr == `IEM_OFF_GATED
                         || wr.addr == `IEM_OFF_PENDING) begin
                bresp_d = `IEM_RESP_SLVERR; // read-only status
            end else begin
                bresp_d = `IEM_RESP_SLVERR; // unmapped
            end
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // each ready again once its own half is not held and no response waits
        awready_d = !aw_held_d && !bvalid_d;
        wready_d  = !w_held_d && !bvalid_d;
    end

    // write channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            awaddr_q     <= '0;
            wdata_q      <= '0;
            wstrb_q      <= '0;
            bvalid_q     <= 1'b0;
            bresp_q      <= `IEM_RESP_OKAY;
            ena_first_q  <= `IEM_RST_FIRST;
            ena_second_q <= `IEM_RST_SECOND;
            awready_q    <= 1'b0;
            wready_q     <= 1'b0;
        end else begin
            aw_held_q    <= aw_held_d;
            w_held_q     <= w_held_d;
            awaddr_q     <= awaddr_d;
            wdata_q      <= wdata_d;
            wstrb_q      <= wstrb_d;
            bvalid_q     <= bvalid_d;
            bresp_q      <= bresp_d;
            ena_first_q  <= ena_first_d;
            ena_second_q <= ena_second_d;
            awready_q    <= awready_d;
            wready_q     <= wready_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel next-state
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = `IEM_RESP_OKAY;
            if (s_axi_araddr == `IEM_OFF_FIRST) begin
                rdata_d = {16'h0000, ena_first_q};
            end else if (s_axi_araddr == `IEM_OFF_SECOND) begin
                rdata_d = {16'h0000, ena_second_q & `IEM_MASK_SECOND};
            end else if (s_axi_araddr == `IEM_OFF_SOURCES) begin
                rdata_d = req_s2_q;
            end else if (s_axi_araddr == `IEM_OFF_GATED) begin
                rdata_d = irq_gated_q;
            end else if (s_axi_araddr == `IEM_OFF_PENDING) begin
                rdata_d = {31'h00000000, |irq_gated_q};
            end else begin
                rdata_d = 32'h00000000;
                rresp_d = `IEM_RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        // one read at a time: ready while no data waits
        arready_d = !rvalid_d;
    end

    // read channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= `IEM_RESP_OKAY;
            arready_q <= 1'b0;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
            arready_q <= arready_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable vector: low half first register, high half second
    always_comb begin
        en_vec = {ena_second_q, ena_first_q};
    end

    iem_gate u_gate (
        .aclk    (aclk),
        .aresetn (aresetn),
        .req     (req_s2_q),
        .en      (en_vec),
        .gated_q (gated)
    );

    // outputs straight from flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_arready = arready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;
    assign irq_gated_q  = gated;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_unimpl_zero;
        @(posedge aclk) disable iff (!aresetn)
        ena_second_q[`IEM_BIT_UNIMPL] == 1'b0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bit set");
    property p_gate_block;
        @(posedge aclk) disable iff (!aresetn)
        (!en_vec[16 + `IEM_BIT_TMR5]) |=> !irq_gated_q[16 + `IEM_BIT_TMR5];
    endproperty
    a_gate_block: assert property (p_gate_block)
        else $error("timer five passed while disabled");
    property p_gate_pass;
        @(posedge aclk) disable iff (!aresetn)
        (req_s2_q[`IEM_BIT_CMP1] && en_vec[`IEM_BIT_CMP1])
            |=> irq_gated_q[`IEM_BIT_CMP1];
    endproperty
    a_gate_pass: assert property (p_gate_pass)
        else $error("compare one not passed");
    property p_cap1;
        @(posedge aclk) disable iff (!aresetn)
        ##1 irq_gated_q[`IEM_BIT_CAP1] == $past(req_s2_q[1] & en_vec[1]);
    endproperty
    a_cap1: assert property (p_cap1)
        else $error("capture one gating wrong");
    property p_ext0;
        @(posedge aclk) disable iff (!aresetn)
        ##1 irq_gated_q[`IEM_BIT_EXT0] == $past(req_s2_q[0] & en_vec[0]);
    endproperty
    a_ext0: assert property (p_ext0)
        else $error("pin zero gating wrong");
    property p_cmp4;
        @(posedge aclk) disable iff (!aresetn)
        ##1 irq_gated_q[16 + `IEM_BIT_CMP4] == $past(req_s2_q[26] & en_vec[26]);
    endproperty
    a_cmp4: assert property (p_cmp4)
        else $error("compare four gating wrong");
    property p_chg_i2c;
        @(posedge aclk) disable iff (!aresetn)
        ##1 irq_gated_q[19:16] == $past(req_s2_q[19:16] & en_vec[19:16]);
    endproperty
    a_chg_i2c: assert property (p_chg_i2c)
        else $error("change notify or i2c gating wrong");
    property p_any_off;
        @(posedge aclk) disable iff (!aresetn)
        (en_vec == 32'h00000000) [*2] |-> irq_gated_q == 32'h00000000;
    endproperty
    a_any_off: assert property (p_any_off)
        else $error("request passed with all enables clear");
    property p_wr_second;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && wr.addr == `IEM_OFF_SECOND && wr.strb[1] && wr.data[12])
            |=> ena_second_q[`IEM_BIT_TMR5];
    endproperty
    a_wr_second: assert property (p_wr_second)
        else $error("second register write lost");
    property p_tmr5_pass;
        @(posedge aclk) disable iff (!aresetn)
        (req_s2_q[16 + `IEM_BIT_TMR5] && en_vec[16 + `IEM_BIT_TMR5])
            |=> irq_gated_q[16 + `IEM_BIT_TMR5];
    endproperty
    a_tmr5_pass: assert property (p_tmr5_pass)
        else $error("timer five not passed while enabled");
    property p_first_wr;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && wr.addr == `IEM_OFF_FIRST && wr.strb[0])
            |=> ena_first_q[`IEM_BIT_CMP1] == $past(wr.data[`IEM_BIT_CMP1]);
    endproperty
    a_first_wr: assert property (p_first_wr)
        else $error("first register write lost");
    property p_aw_taken;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_awvalid && s_axi_awready) |=> !s_axi_awready;
    endproperty
    a_aw_taken: assert property (p_aw_taken)
        else $error("write address ready stayed high after capture");
endmodule : iem_top

/* tb/iem_top_tb.sv */
// self-checking bench for the interrupt enable registers and request gating
`timescale 1ns/1ps
`include "iem_regs.svh"
module iem_top_tb;
    ////////////////////////////////////////////////////////////////////////////////
    logic        aclk, aresetn;                          // clock and low-active reset
    logic [11:0] s_axi_awaddr, s_axi_araddr;             // bus addresses
    logic [31:0] s_axi_wdata, s_axi_rdata;               // bus data
    logic [3:0]  s_axi_wstrb;                            // byte lanes
    logic [1:0]  s_axi_bresp, s_axi_rresp;               // response codes
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // write handshakes
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // resp/addr handshakes
    logic        s_axi_rvalid, s_axi_rready;             // read data handshake
    logic [31:0] src_req, irq_gated_q;                   // raw flags and gated requests
    logic [31:0] rd, e;                                  // read word, expected gate vector
    logic [1:0]  rsp;                                    // last response code
    int          mismatches, cmp_count, i;               // counters and loop index
    int          bits [9] = '{`IEM_BIT_EXT0, `IEM_BIT_CAP1, `IEM_BIT_CMP1, 16, 17, 18, 19, 26, 28};

    iem_top dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .src_req(src_req), .irq_gated_q(irq_gated_q)
    );

    // 50 mhz clock
    always #10 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // a wait that ran out of cycles
    task hang(input string what);
        mismatches++;
        $display("BAD %s expected handshake seen none", what);
        end_sim();
    endtask : hang

    // word comparison
    task chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    // response code comparison
    task chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_resp

    ////////////////////////////////////////////////////////////////////////////////
    // one write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ha, hw, hb;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            // sample what the next rising edge will see
            @(negedge aclk);
            ha  = s_axi_awvalid && s_axi_awready;
            hw  = s_axi_wvalid && s_axi_wready;
            hb  = s_axi_bvalid && s_axi_bready;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hb) begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        hang("write");
    endtask : axi_wr

    // one read: address held until taken, rready held until data seen
    task automatic axi_rd(input logic [11:0] a);
        logic ha, hr;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            ha  = s_axi_arvalid && s_axi_arready;
            hr  = s_axi_rvalid && s_axi_rready;
            rd  = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
            if (hr) begin
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hang("read");
    endtask : axi_rd

    // let the two sync stages and the gate settle, then look mid-cycle
    task settle;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
    endtask : settle

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        src_req = 32'h0000_0000;
        mismatches = 0;
        cmp_count = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values and an unmapped place
        axi_rd(`IEM_OFF_FIRST);
        chk_word("first after reset", 32'h0000_0000, rd);
        axi_rd(`IEM_OFF_SECOND);
        chk_word("second after reset", 32'h0000_0000, rd);
        axi_rd(12'h0F0);
        chk_word("unmapped read", 32'h0000_0000, rd);
        chk_resp("unmapped read resp", `IEM_RESP_SLVERR, rsp);
        $display("test reset_values done");
        // access kinds, the hole at bit 2, byte lanes, read-only place
        axi_wr(`IEM_OFF_FIRST, 32'hFFFF_FFFF, 4'hF);
        chk_resp("first write resp", `IEM_RESP_OKAY, rsp);
        axi_rd(`IEM_OFF_FIRST);
        chk_word("first all ones", 32'h0000_FFFF, rd);
        axi_wr(`IEM_OFF_SECOND, 32'hFFFF_FFFF, 4'hF);
        axi_rd(`IEM_OFF_SECOND);
        chk_word("second all ones", {16'h0000, `IEM_MASK_SECOND}, rd);
        axi_wr(`IEM_OFF_SECOND, 32'h0000_0000, 4'h1);
        axi_rd(`IEM_OFF_SECOND);
        chk_word("second low lane cleared", 32'h0000_FF00, rd);
        axi_wr(`IEM_OFF_GATED, 32'h0000_0000, 4'hF);
        chk_resp("read-only write resp", `IEM_RESP_SLVERR, rsp);
        axi_rd(`IEM_OFF_FIRST);
        chk_word("first kept", 32'h0000_FFFF, rd);
        axi_wr(12'h0F0, 32'h0000_0001, 4'hF);
        chk_resp("unmapped write resp", `IEM_RESP_SLVERR, rsp);
        axi_rd(`IEM_OFF_FIRST);
        chk_word("first kept after unmapped", 32'h0000_FFFF, rd);
        chk_resp("first read resp", `IEM_RESP_OKAY, rsp);
        $display("test access done");
        // each source but the hole at second register bit 2 passes alone when enabled and is blocked otherwise
        for (i = 0; i < 9; i++) begin
            e = 32'h0000_0001 << bits[i];
            axi_wr(`IEM_OFF_FIRST, {16'h0000, e[15:0]}, 4'hF);
            axi_wr(`IEM_OFF_SECOND, {16'h0000, e[31:16]}, 4'hF);
            src_req <= 32'hFFFF_FFFF;
            settle();
            chk_word("gated single", (bits[i] == 18) ? 32'h0 : e, irq_gated_q);
            @(posedge aclk);
            src_req <= ~e;
            settle();
            chk_word("gated others", 32'h0000_0000, irq_gated_q);
        end
        $display("test gating done");
        // status words: synced flags, gated flags, any pending
        @(posedge aclk);
        src_req <= 32'h1000_0005;
        settle();
        axi_rd(`IEM_OFF_SOURCES);
        chk_word("synced sources", 32'h1000_0005, rd);
        chk_resp("sources resp", `IEM_RESP_OKAY, rsp);
        axi_rd(`IEM_OFF_GATED);
        chk_word("gated word", 32'h1000_0000, rd);
        axi_rd(`IEM_OFF_PENDING);
        chk_word("pending set", 32'h0000_0001, rd);
        @(posedge aclk);
        src_req <= 32'h0000_0005;
        settle();
        axi_rd(`IEM_OFF_PENDING);
        chk_word("pending clear", 32'h0000_0000, rd);
        $display("test status done");
        // reset in mid-run clears every enable
        @(posedge aclk);
        src_req <= 32'hFFFF_FFFF;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`IEM_OFF_SECOND);
        chk_word("second after mid reset", 32'h0000_0000, rd);
        axi_rd(`IEM_OFF_FIRST);
        chk_word("first after mid reset", 32'h0000_0000, rd);
        settle();
        chk_word("gated after mid reset", 32'h0000_0000, irq_gated_q);
        $display("test mid_reset done");
        end_sim();
    end
endmodule : iem_top_tb
